// [common/hbs_defs.vh]
`ifndef HBS_DEFS_VH
`define HBS_DEFS_VH

// Register byte offsets
`define HBS_ADR_CTRL       8'h00
`define HBS_ADR_CONN       8'h04
`define HBS_ADR_REL_TIME   8'h08
`define HBS_ADR_ENG_TIME   8'h0C
`define HBS_ADR_WINDOW     8'h10
`define HBS_ADR_STAGGER    8'h14
`define HBS_ADR_STATUS     8'h18
`define HBS_ADR_STATE      8'h1C

// Control register fields
`define HBS_CTRL_SEL_LSB   0
`define HBS_CTRL_SEL_MSB   2
`define HBS_CTRL_EXT       4
`define HBS_CTRL_MEND      5
`define HBS_CTRL_SAFE      6
`define HBS_CTRL_SS1_OK    7
`define HBS_CTRL_OVR_LSB   8
`define HBS_CTRL_OVR_MSB   9
`define HBS_CTRL_EXT_CMD   12
`define HBS_CTRL_OVR_PAR   13
`define HBS_CTRL_RESET     32'h0000_0001

// Brake selection values
`define HBS_SEL_B1         3'h1
`define HBS_SEL_B2         3'h2
`define HBS_SEL_DUAL       3'h4

// Release override source values
`define HBS_OVR_NONE       2'h0
`define HBS_OVR_PARAM      2'h2
`define HBS_OVR_DI         2'h1
`define HBS_OVR_DI_INV     2'h3

// Connection types
`define HBS_CONN_DIRECT    2'h0
`define HBS_CONN_DIR_MON   2'h1
`define HBS_CONN_CONT      2'h2
`define HBS_CONN_CONT_FB   2'h3
`define HBS_CONN_RESET     32'h0000_0000

// Motion command codes that end with engaging
`define HBS_CMD_ABS        4'h1
`define HBS_CMD_REL        4'h2
`define HBS_CMD_ADD        4'h3
`define HBS_CMD_STOP       4'h5
`define HBS_CMD_HOME       4'h6
`define HBS_CMD_HALT       4'hB

// Timing: one tick per millisecond at a 10 ns clock
`define HBS_CLK_PERIOD_NS  10
`define HBS_TICK_NS        1000000
`define HBS_REL_RESET      16'h0064
`define HBS_ENG_RESET      16'h0064
`define HBS_WIN_RESET      32'h0000_0100
`define HBS_STAG_RESET     16'h0032

// Status bits (sticky, write one to clear)
`define HBS_ST_SUPPLY      0
`define HBS_ST_SHORT       1
`define HBS_ST_PLAUS       2
`define HBS_ST_B1_REL      3
`define HBS_ST_B1_ENG      4
`define HBS_ST_B2_REL      5
`define HBS_ST_B2_ENG      6
`define HBS_ST_MOVED       7
`define HBS_ST_W           8

`endif

// [core/hbs_sequencer.v]
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - External control: outputs follow the command bit only, no automatic engaging on faults.
// - External control: brake two mirrors brake one.
// - Selection 1: brake one releases with first motion command after enable.
// - Released brake engages on fault stop, quick stop, enable off or safe torque off.
// - End-of-motion engaging on codes 1,2,3,5,6,11 when enabled.
// - Release override keeps the brake released regardless of engage events.
// - With safety module, override acts during safe torque off only if permitted.
// - Brake supply and short circuit are monitored; monitoring selectable or off.
// - Primary brake output connection is checked for plausibility; mismatch flagged.
// - Release and engage must complete within configured times; violations flagged.
// - Selection 2: same events, override never releases brake two during torque off.
// - Dual mode: brake two releases at enable.
// - Dual mode: brake one follows commands, general events and end-of-motion engaging.
// - Dual mode: brake two engages on general events or movement while brake one holds.
// - Position leaving standstill window with brake one engaged engages brake two at once.
// - Fault or emergency braking while rotating staggers the two engage commands.
// - Without safety module, primary connection type: direct/monitored or contactor/feedback.
// - With safety module, primary allows no contactor feedback; secondary allows all.
// - Control source selects internal automatic or external brake control.
// - Release and engaging times are separate writable configuration values.

`include "hbs_defs.vh"

// ****************************************************************
// Completion watchdog for one brake
// ****************************************************************
module hbs_watch (
	// Clock and reset
	input wire clk,
	input wire srst,
	input wire tick,
	// Command and feedback
	input wire cmd_rel,
	input wire sense_rel,
	input wire check_en,
	input wire [15:0] rel_time,
	input wire [15:0] eng_time,
	// Violations, one-cycle pulses
	output reg rel_late,
	output reg eng_late
);
	reg cmd_d_reg;
	reg busy_reg;
	reg [15:0] cnt_reg;

	// Restart the window on every command edge; a late or missing feedback is flagged
	always @(posedge clk) begin
		if (srst) begin
			cmd_d_reg <= 1'b0;
			busy_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			rel_late <= 1'b0;
			eng_late <= 1'b0;
		end else begin
			cmd_d_reg <= cmd_rel;
			rel_late <= 1'b0;
			eng_late <= 1'b0;
			if (cmd_rel != cmd_d_reg) begin
				busy_reg <= check_en;
				cnt_reg <= cmd_rel ? rel_time : eng_time;
			end else if (busy_reg) begin
				if (sense_rel == cmd_rel) begin
					busy_reg <= 1'b0;
				end else if (cnt_reg == 16'h0000) begin
					busy_reg <= 1'b0;
					rel_late <= cmd_rel;
					eng_late <= ~cmd_rel;
				end else if (tick) begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
			end
		end
	end
endmodule // hbs_watch

// ****************************************************************
// Holding brake sequencer top
// ****************************************************************
module hbs_sequencer #(
	parameter TICK_DIV = `HBS_TICK_NS / `HBS_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire CLK,
	input wire SRST,
	// Wishbone slave
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	// Drive state and motion
	input wire ENABLE,
	input wire CMD_START,
	input wire CMD_DONE,
	input wire [3:0] CMD_CODE,
	input wire HOME_BY_DEFINE,
	input wire AXIS_ROTATING,
	input wire [31:0] POSITION,
	// Stop events
	input wire FAULT_POWER_OFF,
	input wire FAULT_QUICK_STOP,
	input wire FAULT_EMERGENCY,
	input wire QUICK_STOP_REQ,
	input wire SAFE_TORQUE_OFF,
	// Release override terminal
	input wire OVERRIDE_DI,
	// Brake supply and feedback
	input wire SUPPLY_OK,
	input wire SUPPLY_SHORT,
	input wire B1_LOAD_OK,
	input wire B1_SENSE_REL,
	input wire B2_SENSE_REL,
	// Brake outputs, high means released
	output reg PRIMARY_BRAKE_OUTPUT,
	output reg SECONDARY_BRAKE_OUTPUT
);
	localparam [31:0] TICK_LAST = TICK_DIV - 1;

	reg [31:0] ctrl_reg;
	reg [31:0] conn_reg;
	reg [15:0] rel_time_reg;
	reg [15:0] eng_time_reg;
	reg [31:0] window_reg;
	reg [15:0] stagger_reg;
	reg [`HBS_ST_W-1:0] status_reg;
	reg [31:0] div_reg;
	reg tick_reg;
	reg b1_int_reg;
	reg b2_int_reg;
	reg moved_reg;
	reg [31:0] hold_pos_reg;
	reg [15:0] stag_cnt_reg;
	reg stag_evt_d_reg;
	reg b1_out_d_reg;
	reg [31:0] wmask;
	reg [31:0] rd_next;
	reg [`HBS_ST_W-1:0] status_next;
	reg [31:0] pos_diff;

	wire [2:0] brake_selection = ctrl_reg[`HBS_CTRL_SEL_MSB:`HBS_CTRL_SEL_LSB];
	wire brake_control_source = ctrl_reg[`HBS_CTRL_EXT];
	wire engage_at_motion_end = ctrl_reg[`HBS_CTRL_MEND];
	wire safety_fitted = ctrl_reg[`HBS_CTRL_SAFE];
	wire ss1_permits = ctrl_reg[`HBS_CTRL_SS1_OK];
	wire [1:0] release_override_source = ctrl_reg[`HBS_CTRL_OVR_MSB:`HBS_CTRL_OVR_LSB];
	wire [1:0] primary_output_connection_type = conn_reg[1:0];
	wire [1:0] primary_output_connection_type_safe = conn_reg[5:4];
	wire [1:0] secondary_connection_type = conn_reg[9:8];

	wire acc = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire wr = acc & WB_WE_I;

	// ****************************************************************
	// Event decoding
	// ****************************************************************
	wire fault_evt = FAULT_POWER_OFF | FAULT_QUICK_STOP | FAULT_EMERGENCY;
	wire general_evt = fault_evt | ~ENABLE | QUICK_STOP_REQ | SAFE_TORQUE_OFF;
	wire code_ends = (CMD_CODE == `HBS_CMD_ABS) | (CMD_CODE == `HBS_CMD_REL) |
		(CMD_CODE == `HBS_CMD_ADD) | (CMD_CODE == `HBS_CMD_STOP) |
		(CMD_CODE == `HBS_CMD_HALT) | ((CMD_CODE == `HBS_CMD_HOME) & ~HOME_BY_DEFINE);
	wire motion_end = CMD_DONE & engage_at_motion_end & code_ends;
	wire stag_evt = (FAULT_POWER_OFF | FAULT_EMERGENCY) & AXIS_ROTATING;

	// Release override from the configured source
	wire release_override_signal = (release_override_source == `HBS_OVR_PARAM) ?
		ctrl_reg[`HBS_CTRL_OVR_PAR] :
		(release_override_source == `HBS_OVR_DI) ? OVERRIDE_DI :
		(release_override_source == `HBS_OVR_DI_INV) ? ~OVERRIDE_DI : 1'b0;
	// Safety module gates brake one's override during torque off; brake two's is always blocked
	wire ovr_b1 = release_override_signal &
		(~SAFE_TORQUE_OFF | ~safety_fitted | ss1_permits);
	wire ovr_b2 = release_override_signal & ~SAFE_TORQUE_OFF;

	wire use_b1 = (brake_selection == `HBS_SEL_B1) | (brake_selection == `HBS_SEL_DUAL);
	wire use_b2 = (brake_selection == `HBS_SEL_B2) | (brake_selection == `HBS_SEL_DUAL);
	wire dual = brake_selection == `HBS_SEL_DUAL;

	// ****************************************************************
	// Connection types and supply monitoring
	// ****************************************************************
	// A contactor with feedback is not allowed on the primary output with the module
	wire [1:0] prim_eff = ~safety_fitted ? primary_output_connection_type :
		((primary_output_connection_type_safe == `HBS_CONN_CONT_FB) ? `HBS_CONN_CONT :
		primary_output_connection_type_safe);
	wire prim_direct_mon = prim_eff == `HBS_CONN_DIR_MON;
	wire prim_check = prim_direct_mon | (prim_eff == `HBS_CONN_CONT_FB);
	wire sec_check = safety_fitted & ((secondary_connection_type == `HBS_CONN_DIR_MON) |
		(secondary_connection_type == `HBS_CONN_CONT_FB));
	wire supply_err = prim_direct_mon & ~SUPPLY_OK;
	wire short_err = prim_direct_mon & SUPPLY_SHORT;
	wire plaus_err = prim_direct_mon & ~B1_LOAD_OK;

	wire b1_rel_late;
	wire b1_eng_late;
	wire b2_rel_late;
	wire b2_eng_late;

	// Timing monitors run only under internal control
	hbs_watch u_watch1 (
		.clk(CLK),
		.srst(SRST),
		.tick(tick_reg),
		.cmd_rel(PRIMARY_BRAKE_OUTPUT),
		.sense_rel(B1_SENSE_REL),
		.check_en(prim_check & ~brake_control_source),
		.rel_time(rel_time_reg),
		.eng_time(eng_time_reg),
		.rel_late(b1_rel_late),
		.eng_late(b1_eng_late)
	);

	hbs_watch u_watch2 (
		.clk(CLK),
		.srst(SRST),
		.tick(tick_reg),
		.cmd_rel(SECONDARY_BRAKE_OUTPUT),
		.sense_rel(B2_SENSE_REL),
		.check_en(sec_check & ~brake_control_source),
		.rel_time(rel_time_reg),
		.eng_time(eng_time_reg),
		.rel_late(b2_rel_late),
		.eng_late(b2_eng_late)
	);

	// ****************************************************************
	// Millisecond tick
	// ****************************************************************
	always @(posedge CLK) begin
		if (SRST) begin
			div_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (div_reg == TICK_LAST);
			div_reg <= (div_reg == TICK_LAST) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// Internal brake intent
	// ****************************************************************
	// Standstill distance from the position held when brake one engaged
	always @* begin
		pos_diff = (POSITION >= hold_pos_reg) ? POSITION - hold_pos_reg :
			hold_pos_reg - POSITION;
	end

	// Brake one and single brake two: release on command, engage on events
	always @(posedge CLK) begin
		if (SRST) begin
			b1_int_reg <= 1'b0;
			b2_int_reg <= 1'b0;
			moved_reg <= 1'b0;
			hold_pos_reg <= 32'h0000_0000;
			b1_out_d_reg <= 1'b0;
		end else begin
			b1_out_d_reg <= b1_int_reg;
			if (general_evt | motion_end) begin
				b1_int_reg <= 1'b0;
			end else if (CMD_START & use_b1) begin
				b1_int_reg <= 1'b1;
			end
			// Latch position when brake one closes
			if (b1_out_d_reg & ~b1_int_reg) begin
				hold_pos_reg <= POSITION;
			end
			if (~dual | b1_int_reg | general_evt) begin
				moved_reg <= 1'b0;
			end else if (~b1_out_d_reg & (pos_diff > window_reg)) begin
				moved_reg <= 1'b1;
			end
			if (dual) begin
				if (general_evt | moved_reg) begin
					b2_int_reg <= 1'b0;
				end else if (ENABLE) begin
					b2_int_reg <= 1'b1;
				end
			end else if (general_evt | motion_end) begin
				b2_int_reg <= 1'b0;
			end else if (CMD_START & use_b2) begin
				b2_int_reg <= 1'b1;
			end
		end
	end

	// Stagger: brake two waits after a fault stop of a rotating axis
	always @(posedge CLK) begin
		if (SRST) begin
			stag_cnt_reg <= 16'h0000;
			stag_evt_d_reg <= 1'b0;
		end else begin
			stag_evt_d_reg <= stag_evt;
			if (stag_evt & ~stag_evt_d_reg & dual & SECONDARY_BRAKE_OUTPUT) begin
				stag_cnt_reg <= stagger_reg;
			end else if (tick_reg & (stag_cnt_reg != 16'h0000)) begin
				stag_cnt_reg <= stag_cnt_reg - 16'h0001;
			end
		end
	end

	// ****************************************************************
	// Brake outputs
	// ****************************************************************
	// A moved axis overrides the stagger so brake two closes at once
	always @(posedge CLK) begin
		if (SRST) begin
			PRIMARY_BRAKE_OUTPUT <= 1'b0;
			SECONDARY_BRAKE_OUTPUT <= 1'b0;
		end else if (brake_control_source) begin
			PRIMARY_BRAKE_OUTPUT <= ctrl_reg[`HBS_CTRL_EXT_CMD];
			SECONDARY_BRAKE_OUTPUT <= ctrl_reg[`HBS_CTRL_EXT_CMD];
		end else begin
			PRIMARY_BRAKE_OUTPUT <= use_b1 & (b1_int_reg | ovr_b1);
			SECONDARY_BRAKE_OUTPUT <= use_b2 & (b2_int_reg | ovr_b2 |
				((stag_cnt_reg != 16'h0000) & ~moved_reg));
		end
	end

	// ****************************************************************
	// Wishbone register file
	// ****************************************************************
	// Byte-lane write mask and sticky status with set winning over clear
	always @* begin
		wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
		status_next = status_reg;
		if (wr & (WB_ADR_I == `HBS_ADR_STATUS)) begin
			status_next = status_reg & ~(WB_DAT_I[`HBS_ST_W-1:0] & wmask[`HBS_ST_W-1:0]);
		end
		status_next = status_next | {moved_reg, b2_eng_late, b2_rel_late, b1_eng_late,
			b1_rel_late, plaus_err, short_err, supply_err};
		if (WB_ADR_I == `HBS_ADR_CTRL) begin
			rd_next = ctrl_reg;
		end else if (WB_ADR_I == `HBS_ADR_CONN) begin
			rd_next = conn_reg;
		end else if (WB_ADR_I == `HBS_ADR_REL_TIME) begin
			rd_next = {16'h0000, rel_time_reg};
		end else if (WB_ADR_I == `HBS_ADR_ENG_TIME) begin
			rd_next = {16'h0000, eng_time_reg};
		end else if (WB_ADR_I == `HBS_ADR_WINDOW) begin
			rd_next = window_reg;
		end else if (WB_ADR_I == `HBS_ADR_STAGGER) begin
			rd_next = {16'h0000, stagger_reg};
		end else if (WB_ADR_I == `HBS_ADR_STATUS) begin
			rd_next = {24'h000000, status_reg};
		end else if (WB_ADR_I == `HBS_ADR_STATE) begin
			rd_next = {26'h0000000, b2_int_reg, b1_int_reg, prim_eff,
				SECONDARY_BRAKE_OUTPUT, PRIMARY_BRAKE_OUTPUT};
		end else begin
			rd_next = 32'h0000_0000;
		end
	end

	// Single-wait-state slave; unmapped reads give zero, writes are dropped
	always @(posedge CLK) begin
		if (SRST) begin
			ctrl_reg <= `HBS_CTRL_RESET;
			conn_reg <= `HBS_CONN_RESET;
			rel_time_reg <= `HBS_REL_RESET;
			eng_time_reg <= `HBS_ENG_RESET;
			window_reg <= `HBS_WIN_RESET;
			stagger_reg <= `HBS_STAG_RESET;
			status_reg <= {`HBS_ST_W{1'b0}};
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= acc;
			status_reg <= status_next;
			if (acc & ~WB_WE_I) begin
				WB_DAT_O <= rd_next;
			end
			if (wr) begin
				if (WB_ADR_I == `HBS_ADR_CTRL) begin
					ctrl_reg <= (ctrl_reg & ~wmask) | (WB_DAT_I & wmask);
				end else if (WB_ADR_I == `HBS_ADR_CONN) begin
					conn_reg <= (conn_reg & ~wmask) | (WB_DAT_I & wmask);
				end else if (WB_ADR_I == `HBS_ADR_REL_TIME) begin
					rel_time_reg <= (rel_time_reg & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0]);
				end else if (WB_ADR_I == `HBS_ADR_ENG_TIME) begin
					eng_time_reg <= (eng_time_reg & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0]);
				end else if (WB_ADR_I == `HBS_ADR_WINDOW) begin
					window_reg <= (window_reg & ~wmask) | (WB_DAT_I & wmask);
				end else if (WB_ADR_I == `HBS_ADR_STAGGER) begin
					stagger_reg <= (stagger_reg & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0]);
				end
			end
		end
	end
endmodule // hbs_sequencer

// [tb/hbs_brake_model.sv]
`timescale 1ns/1ns
// ****************************************
// Brake pair with slow feedback contacts
// ****************************************
module hbs_brake_model (
	// Clock
	input wire clk,
	// Coil drive, high means released
	input wire [1:0] coil,
	// Contact delay in cycles
	input wire [7:0] dly,
	// Feedback, high means released
	output logic [1:0] fb
);
	logic [7:0] n_reg [2];
	initial fb = 2'b00;
	// Contact follows its coil only after the armature had time to move
	for (genvar i = 0; i < 2; i++) begin : g_b
		initial n_reg[i] = 8'h00;
		always @(posedge clk) begin
			if (coil[i] == fb[i])
				n_reg[i] <= 8'h00;
			else if (n_reg[i] >= dly)
				fb[i] <= coil[i];
			else
				n_reg[i] <= n_reg[i] + 8'h01;
		end
	end
endmodule // hbs_brake_model

// [tb/hbs_sequencer_chk.sv]
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module hbs_sequencer_chk (
	// Clock and reset
	input wire CLK,
	input wire SRST,
	// Bus
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire WB_ACK_O,
	// Motion and events
	input wire ENABLE,
	input wire CMD_START,
	input wire CMD_DONE,
	input wire [3:0] CMD_CODE,
	input wire HOME_BY_DEFINE,
	input wire AXIS_ROTATING,
	input wire FAULT_POWER_OFF,
	input wire FAULT_QUICK_STOP,
	input wire FAULT_EMERGENCY,
	input wire QUICK_STOP_REQ,
	input wire SAFE_TORQUE_OFF,
	// Brakes
	input wire PRIMARY_BRAKE_OUTPUT,
	input wire SECONDARY_BRAKE_OUTPUT
);
	logic [15:0] c_reg;
	logic [15:0] cd_reg;
	wire evt = FAULT_POWER_OFF | FAULT_QUICK_STOP | FAULT_EMERGENCY | QUICK_STOP_REQ
		| SAFE_TORQUE_OFF;
	wire st = (c_reg == cd_reg);
	wire ext = st && c_reg[4];
	wire nov = st && !c_reg[4] && (c_reg[9:8] == 2'h0);
	wire m1 = nov && (c_reg[2:0] == 3'h1);
	wire m4 = nov && (c_reg[2:0] == 3'h4);
	wire endc = CMD_DONE && c_reg[5] && ((CMD_CODE == 4'h6) ? !HOME_BY_DEFINE
		: (CMD_CODE inside {4'h1, 4'h2, 4'h3, 4'h5, 4'hB}));
	// Control shadow lags one edge, so checks only run once it is stable
	always @(posedge CLK) begin
		if (SRST) begin
			c_reg <= 16'h0001;
			cd_reg <= 16'h0001;
		end else begin
			cd_reg <= c_reg;
			if (WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00) begin
				if (WB_SEL_I[0])
					c_reg[7:0] <= WB_DAT_I[7:0];
				if (WB_SEL_I[1])
					c_reg[15:8] <= WB_DAT_I[15:8];
			end
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	sequence s_go;
		m1 && ENABLE && CMD_START && !evt;
	endsequence
	sequence s_split;
		!PRIMARY_BRAKE_OUTPUT && SECONDARY_BRAKE_OUTPUT;
	endsequence
	property p_rst;
		$fell(SRST) |-> !PRIMARY_BRAKE_OUTPUT && !SECONDARY_BRAKE_OUTPUT;
	endproperty
	property p_ext;
		ext |-> PRIMARY_BRAKE_OUTPUT == c_reg[12];
	endproperty
	property p_mir;
		ext |-> SECONDARY_BRAKE_OUTPUT == PRIMARY_BRAKE_OUTPUT;
	endproperty
	property p_rel;
		s_go |-> ##2 PRIMARY_BRAKE_OUTPUT;
	endproperty
	// A command taken one edge earlier is still on its way to the output
	property p_hold;
		m1 && !CMD_START && !$past(CMD_START) && !PRIMARY_BRAKE_OUTPUT
			|=> !PRIMARY_BRAKE_OUTPUT;
	endproperty
	property p_off;
		m1 && (evt || !ENABLE) |-> ##2 !PRIMARY_BRAKE_OUTPUT;
	endproperty
	property p_end;
		m1 && endc && !CMD_START |-> ##2 !PRIMARY_BRAKE_OUTPUT;
	endproperty
	property p_dual;
		m4 && $rose(ENABLE) && !evt |-> ##2 SECONDARY_BRAKE_OUTPUT;
	endproperty
	property p_stag;
		m4 && PRIMARY_BRAKE_OUTPUT && SECONDARY_BRAKE_OUTPUT && AXIS_ROTATING
			&& $rose(FAULT_POWER_OFF || FAULT_EMERGENCY) |-> ##2 s_split;
	endproperty
	a_rst: assert property (p_rst)
		else $error("brakes not engaged after reset");
	a_ext: assert property (p_ext)
		else $error("external output differs from command");
	a_mir: assert property (p_mir)
		else $error("brakes differ under external control");
	a_rel: assert property (p_rel)
		else $error("brake one not released by command");
	a_hold: assert property (p_hold)
		else $error("brake one released without command");
	a_off: assert property (p_off)
		else $error("brake one not engaged on event");
	a_end: assert property (p_end)
		else $error("brake one not engaged at motion end");
	a_dual: assert property (p_dual)
		else $error("brake two not released at enable");
	a_stag: assert property (p_stag)
		else $error("engage commands not staggered");
endmodule // hbs_sequencer_chk

// [tb/tb.sv]
`timescale 1ns/1ns
// ****************************************
// Bench
// ****************************************
module tb;
	logic CLK = 0;
	logic SRST = 1;
	logic WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, WB_ACK_O;
	logic [7:0] WB_ADR_I = 8'h00;
	logic [3:0] WB_SEL_I = 4'hF;
	logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, POSITION = 32'h0;
	logic ENABLE = 0, CMD_START = 0, CMD_DONE = 0, HOME_BY_DEFINE = 0, AXIS_ROTATING = 0;
	logic [3:0] CMD_CODE = 4'h0;
	logic [4:0] ev = 5'h00;
	logic OVERRIDE_DI = 0, SUPPLY_OK = 1, SUPPLY_SHORT = 0, B1_LOAD_OK = 1;
	logic PRIMARY_BRAKE_OUTPUT, SECONDARY_BRAKE_OUTPUT;
	logic [1:0] sense;
	logic [7:0] dly = 8'h03;
	logic [4:0] tab [8] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h0B, 5'h16, 5'h04};
	logic [31:0] d;
	logic [31:0] rq [$];
	logic [1:0] bq [$];
	int mismatches = 0, num_checks = 0, seed = 83363, i;
	event ev_b;
	always #5 CLK = ~CLK;
	hbs_sequencer #(.TICK_DIV(10)) u_hbs_sequencer (.*, .FAULT_POWER_OFF(ev[0]),
		.FAULT_QUICK_STOP(ev[1]), .FAULT_EMERGENCY(ev[2]), .QUICK_STOP_REQ(ev[3]),
		.SAFE_TORQUE_OFF(ev[4]), .B1_SENSE_REL(sense[1]), .B2_SENSE_REL(sense[0]));
	hbs_brake_model u_hbs_brake_model (.clk(CLK), .dly(dly), .fb(sense),
		.coil({PRIMARY_BRAKE_OUTPUT, SECONDARY_BRAKE_OUTPUT}));
	task report_and_stop;
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task bad(input string m);
		mismatches++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task chk_rd(input logic [31:0] g);
		logic [31:0] e;
		e = rq.pop_front();
		num_checks++;
		if (g !== e)
			bad("read data");
	endtask
	task chk_brk(input logic [1:0] g);
		logic [1:0] e;
		e = bq.pop_front();
		num_checks++;
		if (g !== e)
			bad("brake outputs");
	endtask
	// Results are matched against the oldest note as they appear
	always @(posedge CLK)
		if (WB_ACK_O === 1'b1 && !WB_WE_I)
			chk_rd(WB_DAT_O);
	// Outputs settle a step after the launching edge; the caller keeps its edge timing
	always @(ev_b) begin
		#1;
		chk_brk({PRIMARY_BRAKE_OUTPUT, SECONDARY_BRAKE_OUTPUT});
	end
	task cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task expb(input logic [1:0] v);
		bq.push_back(v);
		->ev_b;
	endtask
	// One bus cycle; the wait is bounded so a dead slave ends the run
	task wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
		int n;
		n = 0;
		@(posedge CLK);
		WB_CYC_I <= 1;
		WB_STB_I <= 1;
		WB_WE_I <= w;
		WB_ADR_I <= a;
		WB_DAT_I <= dt;
		do begin
			@(posedge CLK);
			n++;
		end while (WB_ACK_O !== 1'b1 && n < 20);
		WB_CYC_I <= 0;
		WB_STB_I <= 0;
		if (n >= 20) begin
			bad("bus timeout");
			report_and_stop;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] dt);
		wb(1, a, dt);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(0, a, 32'h0);
	endtask
	task go;
		@(posedge CLK);
		CMD_START <= 1;
		@(posedge CLK);
		CMD_START <= 0;
		cyc(2);
	endtask
	task done(input logic [4:0] t);
		@(posedge CLK);
		CMD_DONE <= 1;
		{HOME_BY_DEFINE, CMD_CODE} <= t;
		@(posedge CLK);
		CMD_DONE <= 0;
		cyc(2);
	endtask
	task setb(input logic en, input logic [4:0] e, input logic [1:0] v);
		@(posedge CLK);
		ENABLE <= en;
		ev <= e;
		cyc(3);
		expb(v);
	endtask
	initial begin
		cyc(4);
		SRST <= 0;
		expb(2'b00);
		rd(8'h00, 32'h1);
		rd(8'h08, 32'h64);
		rd(8'h20, 32'h0);
		d = $random(seed) & 32'hFFFF;
		wr(8'h0C, d);
		rd(8'h0C, d);
		setb(1, 5'h00, 2'b00);
		go;
		expb(2'b10);
		setb(0, 5'h08, 2'b00);
		for (i = 0; i < 5; i++) begin
			setb(1, 5'h00, 2'b00);
			go;
			setb(1, 5'h01 << i, 2'b00);
		end
		setb(1, 5'h00, 2'b00);
		wr(8'h00, 32'h21);
		for (i = 0; i < 8; i++) begin
			go;
			done(tab[i]);
			expb({tab[i] == 5'h16 || tab[i] == 5'h04, 1'b0});
		end
		wr(8'h00, 32'h2201);
		setb(0, 5'h00, 2'b10);
		setb(0, 5'h01, 2'b10);
		wr(8'h00, 32'h101);
		OVERRIDE_DI <= 1;
		setb(0, 5'h00, 2'b10);
		wr(8'h00, 32'h301);
		setb(0, 5'h00, 2'b00);
		OVERRIDE_DI <= 0;
		setb(0, 5'h00, 2'b10);
		wr(8'h00, 32'h2241);
		setb(0, 5'h10, 2'b00);
		wr(8'h00, 32'h22C1);
		setb(0, 5'h10, 2'b10);
		wr(8'h00, 32'h22C2);
		setb(0, 5'h10, 2'b00);
		setb(0, 5'h00, 2'b01);
		wr(8'h00, 32'h1011);
		setb(0, 5'h1F, 2'b11);
		wr(8'h00, 32'h0011);
		setb(0, 5'h00, 2'b00);
		wr(8'h00, 32'h64);
		setb(1, 5'h00, 2'b01);
		go;
		expb(2'b11);
		AXIS_ROTATING <= 1;
		setb(1, 5'h01, 2'b01);
		cyc(520);
		expb(2'b00);
		AXIS_ROTATING <= 0;
		setb(0, 5'h00, 2'b00);
		setb(1, 5'h00, 2'b01);
		go;
		done(5'h01);
		expb(2'b01);
		POSITION <= 32'h100;
		cyc(3);
		expb(2'b01);
		POSITION <= 32'h101;
		cyc(3);
		expb(2'b00);
		rd(8'h18, 32'h80);
		// Moved is a level; it must drop before the sticky bit can be cleared
		setb(0, 5'h00, 2'b00);
		wr(8'h18, 32'h80);
		rd(8'h18, 32'h0);
		SRST <= 1;
		ENABLE <= 0;
		cyc(2);
		SRST <= 0;
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h2);
		setb(1, 5'h00, 2'b00);
		go;
		cyc(40);
		rd(8'h18, 32'h0);
		setb(0, 5'h00, 2'b00);
		cyc(40);
		dly <= 8'd100;
		setb(1, 5'h00, 2'b00);
		go;
		cyc(40);
		rd(8'h18, 32'h08);
		SUPPLY_OK <= 0;
		cyc(3);
		rd(8'h18, 32'h09);
		B1_LOAD_OK <= 0;
		cyc(3);
		rd(8'h18, 32'h0D);
		SUPPLY_SHORT <= 1;
		cyc(3);
		rd(8'h18, 32'h0F);
		report_and_stop;
	end
endmodule // tb
bind hbs_sequencer hbs_sequencer_chk u_hbs_sequencer_chk (.*);
